// ===== design/tlm_unit.sv
// Purpose: two-level page translation unit with its register bank
// Assumes: outside party keeps tables aligned, initialised and sane
// Notes:   no entry cache is kept, so flush commands have nothing to drop
//
// What this block does
// - 4KB pages, per-page attributes
// - directory of 1024 table entries
// - table of 1024 page entries
// - directory entry at base plus 4*index
// - page entry at table plus 4*index
// - physical is page plus offset
// - software aligns directory to 4KB
// - software initialises directory
// - directory entry: table 31:12, bit0 valid
// - software aligns, initialises tables
// - page entry: bit0 valid, page 31:12
// - bit2 permits writes, bit1 reads
// - bit3 overrides attributes from 8:4
// - read override: bits 8,7
// - write override: bits 6,5,4
// - directory base read-write, resets zero
// - status 10:6 faulting master
// - status bit5 fault direction
// - command codes 0 to 6
// - stall-on always; others idle or stalled
// - write-one clear; masked is raw and enable
`timescale 1ns/1ps
module tlm_unit (
  // clock and reset
  input  wire logic clock,
  input  wire logic srst,
  // link to the outside party
  tlm_link_if.unit  link
);
  import tlm_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_DIR_REQ, S_DIR_WAIT, S_PTE_REQ, S_PTE_WAIT
  } tlm_walk_type;

  typedef struct packed {
    tlm_walk_type st;
    logic [31:0]  dir_base;
    logic         paging;
    logic         stall;
    logic         pf_active;
    logic [31:0]  fault_addr;
    logic [4:0]   fault_master;
    logic         fault_dir;
    logic [31:0]  flush_line;
    logic [1:0]   irq_raw;
    logic [1:0]   irq_en;
    logic         gating;
    logic [2:0]   cmd;
    logic [31:0]  la;
    logic         wr;
    logic [4:0]   mid;
    logic [4:0]   dattr;
    logic [31:0]  rdata;
    logic         xl_valid;
    logic [31:0]  xl_paddr;
    logic [4:0]   xl_attr;
    logic         xl_fault;
  } tlm_state_type;

  tlm_state_type s_reg;
  tlm_state_type s_next;

  // entry address: base with index scaled by four
  function automatic logic [31:0] entry_addr(input logic [31:0] base,
                                             input logic [9:0]  idx);
    entry_addr = {base[31:PAGE_BITS], idx, 2'h0};
  endfunction : entry_addr

  logic        idle;
  logic [31:0] status;
  logic        pte_ok;

  assign idle   = (s_reg.st == S_IDLE);
  assign status = {21'h0, s_reg.fault_master, s_reg.fault_dir, 1'b1,
                   idle, s_reg.stall, s_reg.pf_active, s_reg.paging};
  // held back while walking, stalled or faulted
  assign link.cl_ready = idle && !s_reg.stall && !s_reg.pf_active;

  // fetched page entry check
  assign pte_ok = link.mem_rdata[ENT_VALID] &&
                  (s_reg.wr ? link.mem_rdata[ENT_WR_PERM]
                            : link.mem_rdata[ENT_RD_PERM]);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.xl_valid = 1'b0;

    // register reads, one cycle latency
    if (link.reg_rd) begin
      unique case (link.reg_addr)
        OFF_DIR_BASE:      s_next.rdata = s_reg.dir_base;
        OFF_XLATE_STATUS:  s_next.rdata = status;
        OFF_XLATE_COMMAND: s_next.rdata = {29'h0, s_reg.cmd};
        OFF_FAULT_ADDRESS: s_next.rdata = s_reg.fault_addr;
        OFF_FLUSH_ONE:     s_next.rdata = s_reg.flush_line;
        OFF_IRQ_RAW:       s_next.rdata = {30'h0, s_reg.irq_raw};
        OFF_IRQ_ENABLE:    s_next.rdata = {30'h0, s_reg.irq_en};
        OFF_IRQ_MASKED:
          s_next.rdata = {30'h0, s_reg.irq_raw & s_reg.irq_en};
        OFF_CLOCK_GATE:    s_next.rdata = {31'h0, s_reg.gating};
        default:           s_next.rdata = 32'h0;
      endcase
    end

    // clear goes first so an event in the same cycle wins
    if (link.reg_wr) begin
      unique case (link.reg_addr)
        OFF_DIR_BASE:   s_next.dir_base = link.reg_wdata;
        OFF_FLUSH_ONE:  s_next.flush_line = link.reg_wdata;
        OFF_IRQ_CLEAR:
          s_next.irq_raw = s_reg.irq_raw & ~link.reg_wdata[1:0];
        OFF_IRQ_ENABLE: s_next.irq_en = link.reg_wdata[1:0];
        OFF_CLOCK_GATE: s_next.gating = link.reg_wdata[0];
        OFF_XLATE_COMMAND: begin
          s_next.cmd = link.reg_wdata[2:0];
          if (link.reg_wdata[2:0] == CMD_STALL_ON) begin
            s_next.stall = 1'b1;
          end else if (idle || s_reg.stall) begin
            unique case (tlm_cmd_type'(link.reg_wdata[2:0]))
              CMD_PAGING_ON:  s_next.paging = 1'b1;
              CMD_PAGING_OFF: s_next.paging = 1'b0;
              CMD_STALL_OFF:  s_next.stall = 1'b0;
              CMD_FAULT_DONE: s_next.pf_active = 1'b0;
              CMD_UNIT_RESET: begin
                s_next.paging    = 1'b0;
                s_next.stall     = 1'b0;
                s_next.pf_active = 1'b0;
                s_next.dir_base  = DIR_BASE_RESET;
                s_next.irq_raw   = 2'b00;
              end
              // no entry cache, so nothing to flush
              CMD_FLUSH_ALL, CMD_SPARE: ;
            endcase
          end
        end
        default: ;
      endcase
    end

    // ---------------------------------------------------------------
    // table walker
    // ---------------------------------------------------------------
    unique case (s_reg.st)
      S_IDLE: begin
        if (link.cl_valid && link.cl_ready) begin
          s_next.la    = link.cl_addr;
          s_next.wr    = link.cl_write;
          s_next.mid   = link.cl_master;
          s_next.dattr = link.cl_attr;
          if (s_reg.paging) begin
            s_next.st = S_DIR_REQ;
          end else begin
            // untranslated: address passes as is
            s_next.xl_valid = 1'b1;
            s_next.xl_paddr = link.cl_addr;
            s_next.xl_attr  = link.cl_attr;
            s_next.xl_fault = 1'b0;
          end
        end
      end
      S_DIR_REQ, S_PTE_REQ: begin
        if (link.mem_ready) begin
          s_next.st = (s_reg.st == S_DIR_REQ) ? S_DIR_WAIT : S_PTE_WAIT;
        end
      end
      S_DIR_WAIT, S_PTE_WAIT: begin
        if (link.mem_rvalid) begin
          // a fault answer unless a branch below says otherwise
          s_next.st       = S_IDLE;
          s_next.xl_valid = 1'b1;
          s_next.xl_fault = 1'b1;
          s_next.xl_paddr = 32'h0;
          s_next.xl_attr  = s_reg.dattr;
          if (link.mem_error) begin
            s_next.irq_raw[IRQ_BUS_ERROR] = 1'b1;
          end else if (s_reg.st == S_DIR_WAIT &&
                       link.mem_rdata[ENT_VALID]) begin
            s_next.st       = S_PTE_REQ;
            s_next.xl_valid = 1'b0;
            s_next.xl_paddr = {link.mem_rdata[31:ENT_ADDR_LO], 12'h000};
          end else if (s_reg.st == S_PTE_WAIT && pte_ok) begin
            s_next.xl_fault = 1'b0;
            s_next.xl_paddr = {link.mem_rdata[31:ENT_ADDR_LO],
                               s_reg.la[PAGE_BITS-1:0]};
            if (link.mem_rdata[ENT_OVERRIDE]) begin
              if (s_reg.wr) begin
                s_next.xl_attr[2:0] =
                  link.mem_rdata[ENT_WR_BUF:ENT_WR_CACHE];
              end else begin
                s_next.xl_attr[4:3] =
                  link.mem_rdata[ENT_RD_ALLOC:ENT_RD_CACHE];
              end
            end
          end else begin
            s_next.pf_active    = 1'b1;
            s_next.fault_addr   = s_reg.la;
            s_next.fault_master = s_reg.mid;
            s_next.fault_dir    = s_reg.wr;
            s_next.irq_raw[IRQ_PAGE_FAULT] = 1'b1;
          end
        end
      end
      default: s_next.st = S_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // registers and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      s_reg          <= '0;
      s_reg.st       <= S_IDLE;
      s_reg.dir_base <= DIR_BASE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // table address rides in xl_paddr between the two fetches
  assign link.mem_valid = (s_reg.st == S_DIR_REQ) ||
                          (s_reg.st == S_PTE_REQ);
  assign link.mem_addr  = (s_reg.st == S_PTE_REQ)
    ? entry_addr(s_reg.xl_paddr,
                 s_reg.la[PAGE_BITS +: INDEX_BITS])
    : entry_addr(s_reg.dir_base,
                 s_reg.la[PAGE_BITS+INDEX_BITS +: INDEX_BITS]);
  assign link.reg_rdata = s_reg.rdata;
  assign link.xl_valid  = s_reg.xl_valid;
  assign link.xl_paddr  = s_reg.xl_paddr;
  assign link.xl_attr   = s_reg.xl_attr;
  assign link.xl_fault  = s_reg.xl_fault;

endmodule : tlm_unit

// ===== design/tlm_pkg.sv
// Purpose: shared constants and types for the two-level page translator
// Assumes: one clock, synchronous active-high reset
// Notes:   offsets are byte addresses of aligned 32-bit words
package tlm_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [5:0] OFF_DIR_BASE      = 6'h00;
  localparam logic [5:0] OFF_XLATE_STATUS  = 6'h04;
  localparam logic [5:0] OFF_XLATE_COMMAND = 6'h08;
  localparam logic [5:0] OFF_FAULT_ADDRESS = 6'h0c;
  localparam logic [5:0] OFF_FLUSH_ONE     = 6'h10;
  localparam logic [5:0] OFF_IRQ_RAW       = 6'h14;
  localparam logic [5:0] OFF_IRQ_CLEAR     = 6'h18;
  localparam logic [5:0] OFF_IRQ_ENABLE    = 6'h1c;
  localparam logic [5:0] OFF_IRQ_MASKED    = 6'h20;
  localparam logic [5:0] OFF_CLOCK_GATE    = 6'h24;

  // ---------------------------------------------------------------
  // reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [31:0] DIR_BASE_RESET   = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET     = 32'h0000_0018;
  localparam int ST_PAGING      = 0;
  localparam int ST_FAULT       = 1;
  localparam int ST_STALL       = 2;
  localparam int ST_IDLE        = 3;
  localparam int ST_REPLAY_MT   = 4;
  localparam int ST_DIR_BIT     = 5;
  localparam int ST_MID_LO      = 6;
  localparam int ST_MID_HI      = 10;
  localparam int IRQ_PAGE_FAULT = 0;
  localparam int IRQ_BUS_ERROR  = 1;

  // entry fields, shared by directory and page entries
  localparam int ENT_ADDR_LO  = 12;
  localparam int ENT_VALID    = 0;
  localparam int ENT_RD_PERM  = 1;
  localparam int ENT_WR_PERM  = 2;
  localparam int ENT_OVERRIDE = 3;
  localparam int ENT_WR_CACHE = 4;
  localparam int ENT_WR_ALLOC = 5;
  localparam int ENT_WR_BUF   = 6;
  localparam int ENT_RD_CACHE = 7;
  localparam int ENT_RD_ALLOC = 8;
  localparam int PAGE_BITS    = 12;
  localparam int INDEX_BITS   = 10;
  localparam logic [1:0] ENTRY_BYTES_LOG2 = 2'd2;

  // ---------------------------------------------------------------
  // commands
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_PAGING_ON  = 3'h0,
    CMD_PAGING_OFF = 3'h1,
    CMD_STALL_ON   = 3'h2,
    CMD_STALL_OFF  = 3'h3,
    CMD_FLUSH_ALL  = 3'h4,
    CMD_FAULT_DONE = 3'h5,
    CMD_UNIT_RESET = 3'h6,
    CMD_SPARE      = 3'h7
  } tlm_cmd_type;

endpackage : tlm_pkg

// ===== design/tlm_link_if.sv
// Purpose: carrier between the translator and its outside party
// Assumes: every signal sampled on the common clock
// Notes:   outside party owns register access, client requests, memory
`timescale 1ns/1ps
interface tlm_link_if;
  // register port
  logic        reg_wr;
  logic        reg_rd;
  logic [5:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  // client request and translated answer
  logic        cl_valid;
  logic        cl_ready;
  logic [31:0] cl_addr;
  logic        cl_write;
  logic [4:0]  cl_master;
  logic [4:0]  cl_attr;
  logic        xl_valid;
  logic [31:0] xl_paddr;
  logic [4:0]  xl_attr;
  logic        xl_fault;
  // table fetch port
  logic        mem_valid;
  logic        mem_ready;
  logic [31:0] mem_addr;
  logic        mem_rvalid;
  logic [31:0] mem_rdata;
  logic        mem_error;

  modport unit (
    input  reg_wr, reg_rd, reg_addr, reg_wdata,
    output reg_rdata,
    input  cl_valid, cl_addr, cl_write, cl_master, cl_attr,
    output cl_ready, xl_valid, xl_paddr, xl_attr, xl_fault,
    output mem_valid, mem_addr,
    input  mem_ready, mem_rvalid, mem_rdata, mem_error
  );
  modport outside (
    output reg_wr, reg_rd, reg_addr, reg_wdata,
    input  reg_rdata,
    output cl_valid, cl_addr, cl_write, cl_master, cl_attr,
    input  cl_ready, xl_valid, xl_paddr, xl_attr, xl_fault,
    input  mem_valid, mem_addr,
    output mem_ready, mem_rvalid, mem_rdata, mem_error
  );
endinterface : tlm_link_if

// ===== design/tlm_outside.sv
// Purpose: outside party of the translator: software, client, table memory
// Assumes: user side drives plain requests synchronous to clock
// Notes:   sanitises what it hands over so the unit sees legal tables
`timescale 1ns/1ps
module tlm_outside (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // link to the unit
  tlm_link_if.outside      link,
  // register access from software
  input  wire logic        u_reg_wr,
  input  wire logic        u_reg_rd,
  input  wire logic [5:0]  u_reg_addr,
  input  wire logic [31:0] u_reg_wdata,
  output logic      [31:0] u_reg_rdata,
  // client requests
  input  wire logic        u_cl_valid,
  output logic             u_cl_ready,
  input  wire logic [31:0] u_cl_addr,
  input  wire logic        u_cl_write,
  input  wire logic [4:0]  u_cl_master,
  input  wire logic [4:0]  u_cl_attr,
  output logic             u_xl_valid,
  output logic      [31:0] u_xl_paddr,
  output logic      [4:0]  u_xl_attr,
  output logic             u_xl_fault,
  // table memory
  output logic             u_mem_rd,
  output logic      [31:0] u_mem_addr,
  input  wire logic        u_mem_rvalid,
  input  wire logic [31:0] u_mem_rdata,
  input  wire logic        u_mem_error
);
  import tlm_pkg::*;

  typedef struct packed {
    logic        busy;
    logic        mem_rd;
    logic [31:0] mem_addr;
    logic        rvalid;
    logic [31:0] rdata;
    logic        error;
  } tlm_side_type;

  tlm_side_type s_reg;
  tlm_side_type s_next;

  // allocate without cacheable is illegal, so drop the allocate hint
  function automatic logic [31:0] legal_entry(input logic [31:0] e);
    legal_entry = e;
    legal_entry[ENT_RD_ALLOC] = e[ENT_RD_ALLOC] & e[ENT_RD_CACHE];
    legal_entry[ENT_WR_ALLOC] = e[ENT_WR_ALLOC] & e[ENT_WR_CACHE];
    legal_entry[11:9] = 3'b000;
  endfunction : legal_entry

  // ---------------------------------------------------------------
  // table fetch service
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.mem_rd = 1'b0;
    s_next.rvalid = 1'b0;
    if (!s_reg.busy && link.mem_valid) begin
      s_next.busy     = 1'b1;
      s_next.mem_rd   = 1'b1;
      s_next.mem_addr = link.mem_addr;
    end
    if (s_reg.busy && u_mem_rvalid) begin
      s_next.busy   = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rdata  = legal_entry(u_mem_rdata);
      s_next.error  = u_mem_error;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.mem_ready  = !s_reg.busy;
  assign link.mem_rvalid = s_reg.rvalid;
  assign link.mem_rdata  = s_reg.rdata;
  assign link.mem_error  = s_reg.error;
  assign u_mem_rd        = s_reg.mem_rd;
  assign u_mem_addr      = s_reg.mem_addr;

  // ---------------------------------------------------------------
  // software and client pass-through
  // ---------------------------------------------------------------
  // directory base is forced onto a 4KB boundary
  assign link.reg_wdata = (u_reg_addr == OFF_DIR_BASE)
                        ? {u_reg_wdata[31:PAGE_BITS], 12'h000}
                        : u_reg_wdata;
  assign link.reg_wr    = u_reg_wr;
  assign link.reg_rd    = u_reg_rd;
  assign link.reg_addr  = u_reg_addr;
  assign u_reg_rdata    = link.reg_rdata;
  assign link.cl_valid  = u_cl_valid;
  assign link.cl_addr   = u_cl_addr;
  assign link.cl_write  = u_cl_write;
  assign link.cl_master = u_cl_master;
  assign link.cl_attr   = u_cl_attr;
  assign u_cl_ready     = link.cl_ready;
  assign u_xl_valid     = link.xl_valid;
  assign u_xl_paddr     = link.xl_paddr;
  assign u_xl_attr      = link.xl_attr;
  assign u_xl_fault     = link.xl_fault;

endmodule : tlm_outside

// ===== verification/tlm_link_properties.sv
// Purpose: timing and value checks on the translator link
// Assumes: one clock, synchronous active-high reset
// Notes:   the walk is tracked from the link signals alone
`timescale 1ns/1ps
module tlm_link_properties
  import tlm_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        srst,
  // register port
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [5:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  // client and answer
  input wire logic        cl_valid,
  input wire logic        cl_ready,
  input wire logic [31:0] cl_addr,
  input wire logic        cl_write,
  input wire logic [4:0]  cl_attr,
  input wire logic        xl_valid,
  input wire logic [31:0] xl_paddr,
  input wire logic [4:0]  xl_attr,
  input wire logic        xl_fault,
  // table fetch
  input wire logic        mem_valid,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_rvalid,
  input wire logic [31:0] mem_rdata,
  input wire logic        mem_error
);
  logic [31:0] base_reg, la_reg, ent_reg;
  logic [4:0]  attr_reg, exp_attr;
  logic        wr_reg, first_reg, pte_ok, pte_hit;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // the bench only resets the unit while idle
  always_ff @(posedge clock) begin
    if (srst) begin
      base_reg  <= 32'h0;
      first_reg <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == OFF_DIR_BASE)
        base_reg <= reg_wdata;
      if (reg_wr && reg_addr == OFF_XLATE_COMMAND && reg_wdata[2:0] == 3'h6)
        base_reg <= 32'h0;
      if (cl_valid && cl_ready) begin
        la_reg    <= cl_addr;
        wr_reg    <= cl_write;
        attr_reg  <= cl_attr;
        first_reg <= 1'b1;
      end
      if (mem_rvalid) begin
        first_reg <= 1'b0;
        ent_reg   <= mem_rdata;
      end
    end
  end

  always_comb begin
    pte_ok = mem_rdata[0] & (wr_reg ? mem_rdata[2] : mem_rdata[1]);
    pte_hit = mem_rvalid & !first_reg & !mem_error & pte_ok;
    exp_attr = attr_reg;
    if (ent_reg[3])
      exp_attr = wr_reg ? {attr_reg[4:3], ent_reg[6:4]}
                        : {ent_reg[8:7], attr_reg[2:0]};
  end

  property p_dir_addr;
    mem_valid && first_reg
      |-> mem_addr == base_reg + {20'h0, la_reg[31:22], 2'b00};
  endproperty
  property p_pte_addr;
    mem_valid && !first_reg
      |-> mem_addr == {ent_reg[31:12], la_reg[21:12], 2'b00};
  endproperty
  property p_walk_ok;
    pte_hit
      |=> xl_valid && !xl_fault && xl_paddr == {ent_reg[31:12], la_reg[11:0]};
  endproperty
  property p_attr;
    pte_hit |=> xl_attr == exp_attr;
  endproperty
  property p_dir_absent;
    mem_rvalid && first_reg && !mem_error && !mem_rdata[0]
      |=> xl_valid && xl_fault && xl_paddr == 32'h0;
  endproperty
  property p_perm_fault;
    mem_rvalid && !first_reg && !mem_error && !pte_ok
      |=> xl_valid && xl_fault ##1 !cl_ready [*3];
  endproperty
  property p_bus_err;
    mem_rvalid && mem_error |=> xl_valid && xl_fault ##1 cl_ready;
  endproperty
  property p_zero_regs;
    reg_rd && (reg_addr == OFF_IRQ_CLEAR || reg_addr > OFF_CLOCK_GATE)
      |=> reg_rdata == 32'h0;
  endproperty
  property p_base_rd;
    reg_rd && reg_addr == OFF_DIR_BASE |=> reg_rdata == base_reg;
  endproperty
  property p_status_fmt;
    reg_rd && reg_addr == OFF_XLATE_STATUS
      |=> reg_rdata[31:11] == 21'h0 && reg_rdata[ST_REPLAY_MT];
  endproperty

  a_dir_addr: assert property (p_dir_addr)
    else $error("directory fetch address");
  a_pte_addr: assert property (p_pte_addr)
    else $error("page entry fetch address");
  a_walk_ok: assert property (p_walk_ok)
    else $error("physical address wrong");
  a_attr: assert property (p_attr)
    else $error("cache attributes wrong");
  a_dir_absent: assert property (p_dir_absent)
    else $error("absent table not faulted");
  a_perm_fault: assert property (p_perm_fault)
    else $error("denied access not faulted");
  a_bus_err: assert property (p_bus_err)
    else $error("bus error answer wrong");
  a_zero_regs: assert property (p_zero_regs)
    else $error("unmapped read not zero");
  a_base_rd: assert property (p_base_rd)
    else $error("base readback wrong");
  a_status_fmt: assert property (p_status_fmt)
    else $error("status reserved bits wrong");

  c_walk: cover property (pte_hit);
  c_fault: cover property (mem_rvalid && !first_reg && !pte_ok);
  c_err: cover property (mem_rvalid && mem_error);
endmodule : tlm_link_properties

// ===== verification/test_two_level_page_mmu.sv
// Purpose: self-checking bench for both translator ends
// Assumes: bench acts as software, client master and table memory
// Notes:   random tables from a fixed seed, corner addresses first
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module test_two_level_page_mmu;
  import tlm_pkg::*;
  logic        clock, srst, u_reg_wr, u_reg_rd, u_cl_valid, u_cl_write;
  logic [5:0]  u_reg_addr;
  logic [31:0] u_reg_wdata, u_reg_rdata, u_cl_addr, u_xl_paddr;
  logic [4:0]  u_cl_master, u_cl_attr, u_xl_attr;
  logic        u_cl_ready, u_xl_valid, u_xl_fault, u_mem_rd;
  logic [31:0] u_mem_addr, u_mem_rdata;
  logic        u_mem_rvalid, u_mem_error, err_next;
  logic [31:0] mem [logic [31:0]];
  int          fails, num_checks, cycles;
  logic [31:0] rst_val [11] = '{1: 32'h18, default: 32'h0};
  logic [31:0] rw_val [11] = '{0: 32'hffff_f000, 1: 32'h18,
    4: 32'hffff_ffff, 7: 32'h3, 9: 32'h1, default: 32'h0};
  logic [31:0] cmd_mask [7] = '{0: 32'h1, 1: 32'h1, 2: 32'h4, 3: 32'h4,
    default: 32'hffff_ffff};
  logic [31:0] cmd_val [7] = '{0: 32'h1, 2: 32'h4, 1: 32'h0, 3: 32'h0,
    default: 32'h18};

  tlm_link_if link ();
  tlm_unit u_tlm_unit (.*);
  tlm_outside u_tlm_outside (.*);
  tlm_link_properties u_tlm_link_properties (.clock(clock), .srst(srst),
    .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_addr(link.reg_addr),
    .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
    .cl_valid(link.cl_valid), .cl_ready(link.cl_ready),
    .cl_addr(link.cl_addr), .cl_write(link.cl_write),
    .cl_attr(link.cl_attr), .xl_valid(link.xl_valid),
    .xl_paddr(link.xl_paddr), .xl_attr(link.xl_attr),
    .xl_fault(link.xl_fault), .mem_valid(link.mem_valid),
    .mem_addr(link.mem_addr), .mem_rvalid(link.mem_rvalid),
    .mem_rdata(link.mem_rdata), .mem_error(link.mem_error));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic results;
    if (fails == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end

  // table memory answers late at random; idle data is inverted on purpose
  initial begin : table_memory
    logic [31:0] ma;
    {u_mem_rvalid, u_mem_error, u_mem_rdata} = 34'h0;
    forever begin
      @(negedge clock);
      if (u_mem_rd === 1'b1) begin
        ma = u_mem_addr;
        repeat ($urandom_range(2, 0)) @(posedge clock);
        @(posedge clock);
        u_mem_rvalid <= 1'b1;
        u_mem_rdata  <= mem.exists(ma) ? mem[ma] : 32'h0;
        u_mem_error  <= err_next;
        @(posedge clock);
        u_mem_rvalid <= 1'b0;
        u_mem_error  <= 1'b0;
        u_mem_rdata  <= ~u_mem_rdata;
      end
    end
  end

  task automatic reg_wr_t(input logic [5:0] a, input logic [31:0] d);
    @(posedge clock);
    u_reg_wr    <= 1'b1;
    u_reg_addr  <= a;
    u_reg_wdata <= d;
    @(posedge clock);
    u_reg_wr <= 1'b0;
  endtask : reg_wr_t

  task automatic reg_rd_t(input logic [5:0] a, output logic [31:0] d);
    @(posedge clock);
    u_reg_rd   <= 1'b1;
    u_reg_addr <= a;
    @(posedge clock);
    u_reg_rd <= 1'b0;
    @(negedge clock);
    d = u_reg_rdata;
  endtask : reg_rd_t

  task automatic xlate(input logic [31:0] la, input logic [10:0] wma);
    int i;
    @(posedge clock);
    u_cl_valid <= 1'b1;
    u_cl_addr  <= la;
    {u_cl_write, u_cl_master, u_cl_attr} <= wma;
    i = 0;
    do begin @(negedge clock); i++; end while (u_cl_ready !== 1'b1 && i < 50);
    @(posedge clock);
    u_cl_valid <= 1'b0;
    i = 0;
    do begin @(negedge clock); i++; end while (u_xl_valid !== 1'b1 && i < 50);
    `CHK(u_xl_valid, 1'b1)
  endtask : xlate

  task automatic do_reset;
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
  endtask : do_reset

  task automatic chk_regs(input logic rw);
    logic [31:0] d;
    for (int k = 0; k < 11; k++) begin
      if (rw && k != 2) reg_wr_t(6'(4 * k), 32'hffff_ffff);
      reg_rd_t(6'(4 * k), d);
      `CHK(d, rw ? rw_val[k] : rst_val[k])
    end
  endtask : chk_regs

  function automatic logic [37:0] expect_xl(input logic [31:0] la, de, pe,
                                            input logic [10:0] wma);
    logic [4:0] at;
    logic       ok;
    ok = de[0] & pe[0] & (wma[10] ? pe[2] : pe[1]);
    at = wma[4:0];
    if (pe[3]) at = wma[10] ? {at[4:3], pe[6:4]} : {pe[8:7], at[2:0]};
    return ok ? {1'b0, at, pe[31:12], la[11:0]} : {1'b1, 5'h0, 32'h0};
  endfunction : expect_xl

  task automatic after_fault(input logic [31:0] la, input logic [10:0] wma,
                             input logic err);
    logic [31:0] d, en, raw;
    en  = $urandom() & 32'h3;
    raw = err ? 32'h2 : 32'h1;
    reg_rd_t(OFF_IRQ_RAW, d);
    `CHK(d, raw)
    reg_wr_t(OFF_IRQ_ENABLE, en);
    reg_rd_t(OFF_IRQ_MASKED, d);
    `CHK(d, raw & en)
    reg_rd_t(OFF_XLATE_STATUS, d);
    if (err) `CHK(d[1:0], 2'b01)
    else `CHK(d[10:0], {wma[9:5], wma[10], 5'h1b})
    reg_rd_t(OFF_FAULT_ADDRESS, d);
    if (!err) `CHK(d, la)
    reg_wr_t(OFF_IRQ_CLEAR, raw);
    reg_rd_t(OFF_IRQ_RAW, d);
    `CHK(d, 32'h0)
    reg_wr_t(OFF_XLATE_COMMAND, 32'h5);
    reg_rd_t(OFF_XLATE_STATUS, d);
    `CHK(d[ST_FAULT], 1'b0)
  endtask : after_fault

  initial begin : main
    logic [31:0] d, la, base, tbl, de, pe;
    logic [37:0] e;
    logic [10:0] wma;
    srst = 1'b1;
    {u_reg_wr, u_reg_rd, u_cl_valid, u_cl_write, err_next, u_reg_addr,
     u_reg_wdata, u_cl_addr, u_cl_master, u_cl_attr} = 85'h0;
    void'($urandom(41871));
    do_reset();
    chk_regs(1'b0);
    chk_regs(1'b1);
    do_reset();
    chk_regs(1'b0);
    reg_wr_t(OFF_DIR_BASE, 32'h1234_5000);
    for (int c = 0; c < 7; c++) begin
      reg_wr_t(OFF_XLATE_COMMAND, 32'(c));
      reg_rd_t(OFF_XLATE_STATUS, d);
      `CHK(d & cmd_mask[c], cmd_val[c])
      if (c == 2) `CHK(u_cl_ready, 1'b0)
    end
    reg_rd_t(OFF_DIR_BASE, d);
    `CHK(d, 32'h0)
    reg_wr_t(OFF_XLATE_COMMAND, 32'h0);
    for (int i = 0; i < 40; i++) begin
      la   = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : $urandom();
      base = (i == 1) ? 32'h0 : $urandom() & 32'hffff_f000;
      tbl  = $urandom() & 32'hffff_f000;
      de   = tbl | {31'h0, i % 7 != 3};
      pe   = $urandom() & 32'hffff_f1ff;
      pe[8] = pe[8] & pe[7];
      pe[5] = pe[5] & pe[4];
      pe[0] = i % 5 != 4;
      wma  = 11'($urandom());
      err_next = i == 6;
      mem[base + {20'h0, la[31:22], 2'b00}] = de;
      mem[{tbl[31:12], la[21:12], 2'b00}] = pe;
      reg_wr_t(OFF_DIR_BASE, base);
      // mid-walk paging-off must be ignored
      fork
        xlate(la, wma);
        if (i == 2) begin
          repeat (3) @(posedge clock);
          reg_wr_t(OFF_XLATE_COMMAND, 32'h1);
        end
      join
      err_next = 1'b0;
      e = expect_xl(la, de, pe, wma);
      if (i == 6) `CHK(u_xl_fault, 1'b1)
      else `CHK({u_xl_fault, e[37] ? 5'h0 : u_xl_attr, u_xl_paddr}, e)
      if (u_xl_fault === 1'b1) after_fault(la, wma, i == 6);
    end
    reg_rd_t(OFF_XLATE_STATUS, d);
    `CHK(d[ST_PAGING], 1'b1)
    results();
  end
endmodule : test_two_level_page_mmu
